// File: core/sgp_pkg.sv
package sgp_pkg;

	// ------------------------------------------------------------
	// Clock and pulse timing
	// ------------------------------------------------------------
	localparam int unsigned CLK_PERIOD_PS  = 4000;
	localparam int unsigned PULSE_WIDTH_PS = 15000;
	// Width rounds up so the pulse is never shorter than the figure.
	localparam int unsigned PULSE_CYC      = (PULSE_WIDTH_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int unsigned PULSE_CNT_W    = 3;

	// ------------------------------------------------------------
	// Register offsets
	// ------------------------------------------------------------
	localparam logic [7:0] ADDR_CTRL      = 8'h00;
	localparam logic [7:0] ADDR_SLIM      = 8'h04;
	localparam logic [7:0] ADDR_CUT_DATA  = 8'h08;
	localparam logic [7:0] ADDR_CUT_SERVO = 8'h0c;
	localparam logic [7:0] ADDR_STATUS    = 8'h10;

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int unsigned CTRL_ROUTE_LO = 0;
	localparam int unsigned CTRL_ROUTE_HI = 1;
	localparam int unsigned CTRL_DUAL_BW  = 2;
	localparam int unsigned SLIM_DATA_LSB = 0;
	localparam int unsigned SLIM_SERV_LSB = 4;
	localparam int unsigned EQ_W          = 3;
	localparam int unsigned CUT_W         = 7;
	localparam int unsigned ST_TRACK      = 0;
	localparam int unsigned ST_TEST       = 1;
	localparam int unsigned ST_OBS        = 2;
	localparam int unsigned ST_DISCH      = 3;
	localparam int unsigned ST_GATE_LSB   = 4;
	localparam int unsigned ST_FIELD      = 8;

	// ------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------
	localparam logic [1:0]       RST_ROUTE     = 2'h0;
	localparam logic             RST_DUAL_BW   = 1'h0;
	localparam logic [EQ_W-1:0]  RST_EQ_DATA   = 3'h0;
	localparam logic [EQ_W-1:0]  RST_EQ_SERVO  = 3'h7;
	localparam logic [CUT_W-1:0] RST_CUT_DATA  = 7'h00;
	localparam logic [CUT_W-1:0] RST_CUT_SERVO = 7'h00;

	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef enum logic [0:0] {
		SGP_MODE_SEEK  = 1'b0,
		SGP_MODE_TRACK = 1'b1
	} sgp_servo_mode_t;

	localparam sgp_servo_mode_t RST_MODE = SGP_MODE_TRACK;

	// Servo command pins as sampled: gate/hold select and four switches.
	typedef struct packed {
		logic       gate_sel;
		logic [3:0] sw;
	} sgp_servo_cmd_t;

	// Source that drives each burst capacitor channel.
	typedef enum logic [1:0] {
		SGP_SRC_PEAK  = 2'b00,
		SGP_SRC_DIFF  = 2'b01,
		SGP_SRC_ZCROS = 2'b10,
		SGP_SRC_QUAL  = 2'b11
	} sgp_cap_src_t;

	// Burst capacitor controls for the analog servo section.
	typedef struct packed {
		logic [3:0]        gate;
		logic              discharge;
		logic              observe;
		logic              slow_charge;
		sgp_cap_src_t [3:0] src;
	} sgp_burst_ctl_t;

	// Controls handed to the filter and qualifier.
	typedef struct packed {
		logic [CUT_W-1:0] cutoff;
		logic [EQ_W-1:0]  slim;
		logic             hyst_servo;
	} sgp_filt_ctl_t;

	// Test mode controls.
	typedef struct packed {
		logic test_mode;
		logic gain_fixed;
		logic vco_stop;
		logic sync_clk_ext;
		logic synth_clk_ext;
	} sgp_test_ctl_t;

endpackage : sgp_pkg

// File: core/sgp_pulse_shaper.sv
`timescale 1ns/1ps

// Turns the rising edge of a trigger into a pulse of fixed length.
module sgp_pulse_shaper (
	input  wire logic i_clk,
	input  wire logic i_rst,
	input  wire logic i_trig,
	output logic      o_pulse
);

	logic                               trig_q;
	logic                               trig_d;
	logic [sgp_pkg::PULSE_CNT_W-1:0]    cnt_q;
	logic [sgp_pkg::PULSE_CNT_W-1:0]    cnt_d;
	logic                               pulse_q;
	logic                               pulse_d;

	// --------------------------------------------------------------
	// Width counter
	// --------------------------------------------------------------

	// A new edge inside a running pulse restarts the count, so edges four cycles
	// apart or closer stretch the pulse; a lone edge's width depends only on the clock.
	always_comb begin
		trig_d  = i_trig;
		cnt_d   = cnt_q;
		pulse_d = pulse_q;
		if (i_trig && !trig_q) begin
			cnt_d   = sgp_pkg::PULSE_CNT_W'(sgp_pkg::PULSE_CYC - 1);
			pulse_d = 1'b1;
		end else if (cnt_q != '0) begin
			cnt_d = cnt_q - 1'b1;
		end else begin
			pulse_d = 1'b0;
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			trig_q  <= 1'b0;
			cnt_q   <= '0;
			pulse_q <= 1'b0;
		end else begin
			trig_q  <= trig_d;
			cnt_q   <= cnt_d;
			pulse_q <= pulse_d;
		end
	end

	assign o_pulse = pulse_q;

endmodule : sgp_pulse_shaper

// File: core/sgp_servo_gate_pulse_route_ctrl.sv
`timescale 1ns/1ps

// Behaviour
// - Route code 00 enables no pins; 01 enables only the pulse output pin.
// - Codes 10 and 11 enable both pins and feed the synchronizer externally.
// - Code 11 is test mode: fixed gain, VCOs stopped, test clocks used.
// - Each lone detector output pulse is four cycles wide, at least 15 ns; edges four cycles apart or closer stretch it.
// - Gate/hold select and four switch pins are decoded as a truth table.
// - Gate select high gates each channel whose switch is high; mode kept.
// - Gate select low: switch one alone latches track follow, switch three alone seek.
// - Gate select low with switch four discharges all burst capacitors.
// - Gate select low with switch two routes internal signals to channels.
// - Track follow mode charges the peak detectors slower than seek mode.
// - Pulse slimming setting has eight steps.
// - Cutoff setting has 128 steps, held separately for data and servo.
// - With dual bandwidth enabled the field pin picks the cutoff setting.
// - The field pin picks data or servo hysteresis level.
// - Both route bits reset cleared: pins disabled, test mode off.
module sgp_servo_gate_pulse_route_ctrl (
	input  wire logic                  i_clk,
	input  wire logic                  i_rst,
	// Register port.
	input  wire logic [7:0]            i_addr,
	input  wire logic [31:0]           i_wdata,
	input  wire logic                  i_wr,
	input  wire logic                  i_rd,
	output logic      [31:0]           o_rdata,
	// Pins and pulse sources.
	input  wire logic                  i_gate_sel,
	input  wire logic                  i_servo_sw_one,
	input  wire logic                  i_servo_sw_two,
	input  wire logic                  i_servo_sw_three,
	input  wire logic                  i_servo_sw_four,
	input  wire logic                  i_field_select_pin,
	input  wire logic                  i_ext_pulse_in,
	input  wire logic                  i_pd_pulse,
	// Pulse routing.
	output logic                       o_pulse_out_pin,
	output logic                       o_pulse_out_en,
	output logic                       o_ext_pulse_in_en,
	output logic                       o_sync_pulse,
	// Analog section controls.
	output sgp_pkg::sgp_test_ctl_t     o_test_ctl,
	output sgp_pkg::sgp_burst_ctl_t    o_burst_ctl,
	output sgp_pkg::sgp_filt_ctl_t     o_filt_ctl
);

	// --------------------------------------------------------------
	// Pin synchronisers
	// --------------------------------------------------------------

	sgp_pkg::sgp_servo_cmd_t cmd_m_q;
	sgp_pkg::sgp_servo_cmd_t cmd_s_q;
	logic [2:0]              pin_m_q;
	logic [2:0]              pin_s_q;
	logic [2:0]              pin_raw;
	sgp_pkg::sgp_servo_cmd_t cmd_raw;

	assign cmd_raw = '{gate_sel: i_gate_sel,
		sw: {i_servo_sw_four, i_servo_sw_three, i_servo_sw_two, i_servo_sw_one}};
	assign pin_raw = {i_pd_pulse, i_ext_pulse_in, i_field_select_pin};

	// Every pin passes two flops; the first stage feeds only the second.
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			cmd_m_q <= '0;
			cmd_s_q <= '0;
			pin_m_q <= 3'h0;
			pin_s_q <= 3'h0;
		end else begin
			cmd_m_q <= cmd_raw;
			cmd_s_q <= cmd_m_q;
			pin_m_q <= pin_raw;
			pin_s_q <= pin_m_q;
		end
	end

	logic field_servo;
	logic ext_pulse_s;
	logic pd_pulse_s;

	assign field_servo = pin_s_q[0];
	assign ext_pulse_s = pin_s_q[1];
	assign pd_pulse_s  = pin_s_q[2];

	// --------------------------------------------------------------
	// Register file
	// --------------------------------------------------------------

	logic [1:0]                  route_q;
	logic [1:0]                  route_d;
	logic                        dual_bw_q;
	logic                        dual_bw_d;
	logic [sgp_pkg::EQ_W-1:0]    eq_data_q;
	logic [sgp_pkg::EQ_W-1:0]    eq_data_d;
	logic [sgp_pkg::EQ_W-1:0]    eq_servo_q;
	logic [sgp_pkg::EQ_W-1:0]    eq_servo_d;
	logic [sgp_pkg::CUT_W-1:0]   cut_data_q;
	logic [sgp_pkg::CUT_W-1:0]   cut_data_d;
	logic [sgp_pkg::CUT_W-1:0]   cut_servo_q;
	logic [sgp_pkg::CUT_W-1:0]   cut_servo_d;
	logic [31:0]                 rdata_q;
	logic [31:0]                 rdata_d;
	logic [31:0]                 status;

	// Writes land one edge after the strobe; reads answer in the next cycle.
	always_comb begin
		route_d     = route_q;
		dual_bw_d   = dual_bw_q;
		eq_data_d   = eq_data_q;
		eq_servo_d  = eq_servo_q;
		cut_data_d  = cut_data_q;
		cut_servo_d = cut_servo_q;
		rdata_d     = 32'h0;
		if (i_wr) begin
			if (i_addr == sgp_pkg::ADDR_CTRL) begin
				route_d   = {i_wdata[sgp_pkg::CTRL_ROUTE_HI], i_wdata[sgp_pkg::CTRL_ROUTE_LO]};
				dual_bw_d = i_wdata[sgp_pkg::CTRL_DUAL_BW];
			end else if (i_addr == sgp_pkg::ADDR_SLIM) begin
				eq_data_d  = i_wdata[sgp_pkg::SLIM_DATA_LSB +: sgp_pkg::EQ_W];
				eq_servo_d = i_wdata[sgp_pkg::SLIM_SERV_LSB +: sgp_pkg::EQ_W];
			end else if (i_addr == sgp_pkg::ADDR_CUT_DATA) begin
				cut_data_d = i_wdata[sgp_pkg::CUT_W-1:0];
			end else if (i_addr == sgp_pkg::ADDR_CUT_SERVO) begin
				cut_servo_d = i_wdata[sgp_pkg::CUT_W-1:0];
			end
		end
		if (i_rd) begin
			if (i_addr == sgp_pkg::ADDR_CTRL) begin
				rdata_d[sgp_pkg::CTRL_ROUTE_LO] = route_q[0];
				rdata_d[sgp_pkg::CTRL_ROUTE_HI] = route_q[1];
				rdata_d[sgp_pkg::CTRL_DUAL_BW]  = dual_bw_q;
			end else if (i_addr == sgp_pkg::ADDR_SLIM) begin
				rdata_d[sgp_pkg::SLIM_DATA_LSB +: sgp_pkg::EQ_W] = eq_data_q;
				rdata_d[sgp_pkg::SLIM_SERV_LSB +: sgp_pkg::EQ_W] = eq_servo_q;
			end else if (i_addr == sgp_pkg::ADDR_CUT_DATA) begin
				rdata_d[sgp_pkg::CUT_W-1:0] = cut_data_q;
			end else if (i_addr == sgp_pkg::ADDR_CUT_SERVO) begin
				rdata_d[sgp_pkg::CUT_W-1:0] = cut_servo_q;
			end else if (i_addr == sgp_pkg::ADDR_STATUS) begin
				rdata_d = status;
			end
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			route_q     <= sgp_pkg::RST_ROUTE;
			dual_bw_q   <= sgp_pkg::RST_DUAL_BW;
			eq_data_q   <= sgp_pkg::RST_EQ_DATA;
			eq_servo_q  <= sgp_pkg::RST_EQ_SERVO;
			cut_data_q  <= sgp_pkg::RST_CUT_DATA;
			cut_servo_q <= sgp_pkg::RST_CUT_SERVO;
			rdata_q     <= 32'h0;
		end else begin
			route_q     <= route_d;
			dual_bw_q   <= dual_bw_d;
			eq_data_q   <= eq_data_d;
			eq_servo_q  <= eq_servo_d;
			cut_data_q  <= cut_data_d;
			cut_servo_q <= cut_servo_d;
			rdata_q     <= rdata_d;
		end
	end

	assign o_rdata = rdata_q;

	// --------------------------------------------------------------
	// Pulse routing and test mode
	// --------------------------------------------------------------

	logic                   pd_shaped;
	logic                   out_pin_q;
	logic                   out_pin_d;
	logic                   out_en_q;
	logic                   out_en_d;
	logic                   in_en_q;
	logic                   in_en_d;
	logic                   sync_q;
	logic                   sync_d;
	sgp_pkg::sgp_test_ctl_t test_q;
	sgp_pkg::sgp_test_ctl_t test_d;

	sgp_pulse_shaper u_shaper (
		.i_clk   (i_clk),
		.i_rst   (i_rst),
		.i_trig  (pd_pulse_s),
		.o_pulse (pd_shaped)
	);

	// The external path carries its pulse as given; only the detector pulse
	// is shaped here, since the external source sets its own width.
	always_comb begin
		out_en_d  = route_q != 2'h0;
		in_en_d   = route_q[1];
		out_pin_d = out_en_d & pd_shaped;
		sync_d    = route_q[1] ? ext_pulse_s : pd_shaped;
		test_d.test_mode     = &route_q;
		test_d.gain_fixed    = &route_q;
		test_d.vco_stop      = &route_q;
		test_d.sync_clk_ext  = &route_q;
		test_d.synth_clk_ext = &route_q;
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			out_pin_q <= 1'b0;
			out_en_q  <= 1'b0;
			in_en_q   <= 1'b0;
			sync_q    <= 1'b0;
			test_q    <= '0;
		end else begin
			out_pin_q <= out_pin_d;
			out_en_q  <= out_en_d;
			in_en_q   <= in_en_d;
			sync_q    <= sync_d;
			test_q    <= test_d;
		end
	end

	assign o_pulse_out_pin   = out_pin_q;
	assign o_pulse_out_en    = out_en_q;
	assign o_ext_pulse_in_en = in_en_q;
	assign o_sync_pulse      = sync_q;
	assign o_test_ctl        = test_q;

	// --------------------------------------------------------------
	// Servo command decode
	// --------------------------------------------------------------

	sgp_pkg::sgp_servo_mode_t mode_q;
	sgp_pkg::sgp_servo_mode_t mode_d;
	sgp_pkg::sgp_burst_ctl_t  burst_q;
	sgp_pkg::sgp_burst_ctl_t  burst_d;

	always_comb begin
		mode_d  = mode_q;
		burst_d = '0;
		if (cmd_s_q.gate_sel) begin
			burst_d.gate = cmd_s_q.sw;
		end else begin
			if (cmd_s_q.sw[0] && !cmd_s_q.sw[2]) begin
				mode_d = sgp_pkg::SGP_MODE_TRACK;
			end else if (cmd_s_q.sw[2] && !cmd_s_q.sw[0]) begin
				mode_d = sgp_pkg::SGP_MODE_SEEK;
			end
			burst_d.discharge = cmd_s_q.sw[3];
			burst_d.observe = cmd_s_q.sw[1];
		end
		burst_d.slow_charge = mode_d == sgp_pkg::SGP_MODE_TRACK;
		if (burst_d.observe) begin
			burst_d.src[0] = sgp_pkg::SGP_SRC_DIFF;
			burst_d.src[1] = sgp_pkg::SGP_SRC_DIFF;
			burst_d.src[2] = sgp_pkg::SGP_SRC_ZCROS;
			burst_d.src[3] = sgp_pkg::SGP_SRC_QUAL;
		end else begin
			burst_d.src = '{default: sgp_pkg::SGP_SRC_PEAK};
		end
	end

	// The mode is the only servo state that outlives the pin levels.
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			mode_q  <= sgp_pkg::RST_MODE;
			burst_q <= '0;
		end else begin
			mode_q  <= mode_d;
			burst_q <= burst_d;
		end
	end

	assign o_burst_ctl = burst_q;

	// --------------------------------------------------------------
	// Filter and qualifier selection
	// --------------------------------------------------------------

	sgp_pkg::sgp_filt_ctl_t filt_q;
	sgp_pkg::sgp_filt_ctl_t filt_d;

	// Switching here needs no register access, so bandwidth can follow the
	// field pin between data and servo fields.
	always_comb begin
		if (dual_bw_q && field_servo) begin
			filt_d.cutoff = cut_servo_q;
			filt_d.slim   = eq_servo_q;
		end else begin
			filt_d.cutoff = cut_data_q;
			filt_d.slim   = eq_data_q;
		end
		filt_d.hyst_servo = field_servo;
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			filt_q <= '0;
		end else begin
			filt_q <= filt_d;
		end
	end

	assign o_filt_ctl = filt_q;

	// --------------------------------------------------------------
	// Status word
	// --------------------------------------------------------------

	// Status reflects registered state, three edges behind the servo pins, two behind the field pin.
	always_comb begin
		status                                  = 32'h0;
		status[sgp_pkg::ST_TRACK]               = mode_q == sgp_pkg::SGP_MODE_TRACK;
		status[sgp_pkg::ST_TEST]                = test_q.test_mode;
		status[sgp_pkg::ST_OBS]                 = burst_q.observe;
		status[sgp_pkg::ST_DISCH]               = burst_q.discharge;
		status[sgp_pkg::ST_GATE_LSB +: 4]       = burst_q.gate;
		status[sgp_pkg::ST_FIELD]               = field_servo;
	end

endmodule : sgp_servo_gate_pulse_route_ctrl

// File: tb/sgp_sva.sv
`timescale 1ns/1ps

// ------------------------------------------------------------
// Port checker
// ------------------------------------------------------------
module sgp_sva (
	input wire logic                    i_clk,
	input wire logic                    i_rst,
	input wire logic [7:0]              i_addr,
	input wire logic [31:0]             i_wdata,
	input wire logic                    i_wr,
	input wire logic                    i_gate_sel,
	input wire logic                    i_servo_sw_one,
	input wire logic                    i_servo_sw_two,
	input wire logic                    i_servo_sw_three,
	input wire logic                    i_servo_sw_four,
	input wire logic                    i_field_select_pin,
	input wire logic                    o_pulse_out_pin,
	input wire logic                    o_pulse_out_en,
	input wire logic                    o_ext_pulse_in_en,
	input wire sgp_pkg::sgp_test_ctl_t  o_test_ctl,
	input wire sgp_pkg::sgp_burst_ctl_t o_burst_ctl,
	input wire sgp_pkg::sgp_filt_ctl_t  o_filt_ctl
);
	logic [1:0] rt_q;
	logic [1:0] rt_d;
	logic [2:0] age_q;
	logic [2:0] age_d;
	logic       ok_w;
	logic       trk_w;
	logic       sek_w;
	logic [3:0] gat_w;

	// Route shadow, and a settle count because pins need three edges to reach outputs.
	always_comb begin
		rt_d  = (i_wr && i_addr == sgp_pkg::ADDR_CTRL) ? i_wdata[1:0] : rt_q;
		age_d = (age_q == 3'h7) ? age_q : age_q + 3'h1;
	end

	// Helper registers.
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			rt_q  <= 2'h0;
			age_q <= 3'h0;
		end else begin
			rt_q  <= rt_d;
			age_q <= age_d;
		end
	end

	// Pin decodes as the controller presents them.
	assign ok_w  = (age_q == 3'h7);
	assign trk_w = !i_gate_sel && i_servo_sw_one && !i_servo_sw_three;
	assign sek_w = !i_gate_sel && i_servo_sw_three && !i_servo_sw_one;
	assign gat_w = {i_servo_sw_four, i_servo_sw_three, i_servo_sw_two, i_servo_sw_one};

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_rst);

	sequence s_track;
		ok_w && $past(trk_w, 3);
	endsequence
	sequence s_seek;
		ok_w && $past(sek_w, 3);
	endsequence

	a_out_en_route: assert property (o_pulse_out_en == |$past(rt_q))
		else $error("pulse output enable does not follow route");
	a_in_en_route: assert property (o_ext_pulse_in_en == $past(rt_q[1]))
		else $error("external input enable does not follow route");
	a_test_route: assert property (o_test_ctl == (&$past(rt_q) ? 5'h1f : 5'h00))
		else $error("test controls do not follow route");
	a_pulse_width: assert property ($rose(o_pulse_out_pin) |-> o_pulse_out_pin[*4] ##1 !o_pulse_out_pin)
		else $error("pulse width is not four cycles");
	a_gate_decode: assert property (ok_w |-> o_burst_ctl.gate == ($past(i_gate_sel, 3) ? $past(gat_w, 3) : 4'h0))
		else $error("gate decode wrong");
	a_disch_decode: assert property (ok_w |-> o_burst_ctl.discharge ==
		(!$past(i_gate_sel, 3) && $past(i_servo_sw_four, 3)))
		else $error("discharge decode wrong");
	a_obs_decode: assert property (ok_w |-> o_burst_ctl.observe ==
		(!$past(i_gate_sel, 3) && $past(i_servo_sw_two, 3)))
		else $error("observe decode wrong");
	a_obs_source: assert property (o_burst_ctl.observe |-> o_burst_ctl.src == 8'he5)
		else $error("observe sources wrong");
	a_track_latch: assert property (s_track |-> o_burst_ctl.slow_charge)
		else $error("track follow not latched");
	a_seek_latch: assert property (s_seek |-> !o_burst_ctl.slow_charge)
		else $error("seek not latched");
	a_mode_hold: assert property (ok_w && $changed(o_burst_ctl.slow_charge) |-> $past(trk_w, 3) || $past(sek_w, 3))
		else $error("mode changed without latch command");
	a_hyst_field: assert property (ok_w |-> o_filt_ctl.hyst_servo == $past(i_field_select_pin, 3))
		else $error("hysteresis select wrong");
endmodule : sgp_sva

bind sgp_servo_gate_pulse_route_ctrl sgp_sva u_sgp_sva (.i_clk, .i_rst, .i_addr, .i_wdata, .i_wr,
	.i_gate_sel, .i_servo_sw_one, .i_servo_sw_two, .i_servo_sw_three, .i_servo_sw_four,
	.i_field_select_pin, .o_pulse_out_pin, .o_pulse_out_en, .o_ext_pulse_in_en, .o_test_ctl,
	.o_burst_ctl, .o_filt_ctl);

// File: tb/sgp_ctrl_model.sv
`timescale 1ns/1ps

// ------------------------------------------------------------
// Servo controller model
// ------------------------------------------------------------
module sgp_ctrl_model (
	input  wire logic                    i_clk,
	input  wire sgp_pkg::sgp_servo_cmd_t i_cmd,
	input  wire logic                    i_allow_bad,
	output logic                         o_gate_sel,
	output logic [3:0]                   o_sw
);
	sgp_pkg::sgp_servo_cmd_t pins_q = '0;
	logic                    bad_w;

	// drop forbidden commands unless allowed
	// A well-behaved controller never sends both latches or observation unless told to.
	assign bad_w = !i_cmd.gate_sel && (i_cmd.sw[1] || (i_cmd.sw[0] && i_cmd.sw[2])) && !i_allow_bad;

	// five pin levels
	// All five pins move at one edge so the device never sees a half-made command.
	always @(posedge i_clk) begin
		if (!bad_w) begin
			pins_q <= i_cmd;
		end
	end
	assign o_gate_sel = pins_q.gate_sel;
	assign o_sw       = pins_q.sw;
endmodule : sgp_ctrl_model

// File: tb/tb_top.sv
`timescale 1ns/1ps

// ------------------------------------------------------------
// Bench top
// ------------------------------------------------------------
module tb_top;
	logic clk = 1'b0, rst = 1'b1, bus_wr = 1'b0, bus_rd = 1'b0;
	logic field = 1'b0, ext_in = 1'b0, pd = 1'b0, gs, pout, pen, ien, spul;
	logic [7:0]              addr = 8'h00;
	logic [31:0]             wdata = 32'h0, rdata;
	logic [3:0]              sw;
	sgp_pkg::sgp_servo_cmd_t cmd = '0;
	sgp_pkg::sgp_test_ctl_t  tctl;
	sgp_pkg::sgp_burst_ctl_t bctl;
	sgp_pkg::sgp_filt_ctl_t  fctl;
	int                      n_fail = 0, checks_done = 0;

	// Free-running clock of 4 ns.
	always #2 clk = ~clk;

	sgp_servo_gate_pulse_route_ctrl u_sgp_servo_gate_pulse_route_ctrl (.i_clk(clk), .i_rst(rst),
		.i_addr(addr), .i_wdata(wdata), .i_wr(bus_wr), .i_rd(bus_rd), .o_rdata(rdata),
		.i_gate_sel(gs), .i_servo_sw_one(sw[0]), .i_servo_sw_two(sw[1]),
		.i_servo_sw_three(sw[2]), .i_servo_sw_four(sw[3]), .i_field_select_pin(field),
		.i_ext_pulse_in(ext_in), .i_pd_pulse(pd), .o_pulse_out_pin(pout), .o_pulse_out_en(pen),
		.o_ext_pulse_in_en(ien), .o_sync_pulse(spul), .o_test_ctl(tctl), .o_burst_ctl(bctl),
		.o_filt_ctl(fctl));
	sgp_ctrl_model u_sgp_ctrl_model (.i_clk(clk), .i_cmd(cmd), .i_allow_bad(1'b1),
		.o_gate_sel(gs), .o_sw(sw));

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : report_and_stop

	// Bus cycles: one strobe cycle each; read data stand in the cycle after the strobe.
	task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		bus_wr <= 1'b1;
		addr   <= a;
		wdata  <= d;
		@(posedge clk);
		bus_wr <= 1'b0;
	endtask : reg_wr

	task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk);
		bus_rd <= 1'b1;
		addr   <= a;
		@(posedge clk);
		bus_rd <= 1'b0;
		#1;
		d = rdata;
	endtask : reg_rd

	task automatic settle(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : settle

	// Fires one pulse three cycles long and counts high cycles on both pulse outputs.
	task automatic fire(input logic ext, output int n_o, output int n_s);
		n_o = 0;
		n_s = 0;
		for (int i = 0; i < 16; i++) begin
			@(posedge clk);
			pd     <= (i < 3) && !ext;
			ext_in <= (i < 3) && ext;
			#1;
			n_o += (pout === 1'b1);
			n_s += (spul === 1'b1);
		end
	endtask : fire

	function automatic logic [31:0] exp_status(input logic [4:0] p, input logic m,
		input logic [1:0] r, input logic f);
		return {23'h0, f, p[4] ? p[3:0] : 4'h0, !p[4] & p[3], !p[4] & p[1], &r, m};
	endfunction : exp_status

	function automatic logic next_mode(input logic [4:0] p, input logic m);
		if (!p[4] && p[0] != p[2]) begin
			return p[0];
		end
		return m;
	endfunction : next_mode

	// A hang is cut short here and counted.
	initial begin
		repeat (60000) @(posedge clk);
		n_fail++;
		report_and_stop();
	end

	initial begin
		logic [31:0] d, ra[6], rv[6], rm[6], vs[3];
		logic [4:0]  p;
		logic        m;
		int          no, ns;
		void'($urandom(32'h546a));
		m  = 1'b1;
		ra = '{sgp_pkg::ADDR_CTRL, sgp_pkg::ADDR_SLIM, sgp_pkg::ADDR_CUT_DATA,
			sgp_pkg::ADDR_CUT_SERVO, sgp_pkg::ADDR_STATUS, 8'h14};
		rv = '{0, {25'h0, sgp_pkg::RST_EQ_SERVO, 1'b0, sgp_pkg::RST_EQ_DATA}, 0, 0,
			exp_status(5'h0, 1'b1, 2'h3, 1'b0), 0}; // Control was written first: test mode is on.
		rm = '{32'h7, 32'h77, 32'h7f, 32'h7f, exp_status(5'h0, 1'b1, 2'h3, 1'b0), 0};
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		check("pins_rst", {pen, ien, tctl}, 32'h0);
		for (int i = 0; i < 6; i++) begin
			reg_rd(ra[i][7:0], d);
			check("reg_rst", d, rv[i]);
			reg_wr(ra[i][7:0], 32'hffffffff);
		end
		for (int i = 0; i < 6; i++) begin
			reg_rd(ra[i][7:0], d);
			check("reg_back", d, rm[i]);
		end
		$display("test registers done");
		for (int r = 0; r < 4; r++) begin
			logic [1:0] c;
			c = 2'(r);
			reg_wr(sgp_pkg::ADDR_CTRL, 32'(r));
			settle(2);
			check("out_en", pen, |c);
			check("in_en", ien, c[1]);
			check("test", tctl, (&c) ? 32'h1f : 32'h0);
			fire(1'b0, no, ns);
			check("pulse_out", no, (c != 2'h0) ? sgp_pkg::PULSE_CYC : 0);
			check("sync_int", ns, c[1] ? 0 : sgp_pkg::PULSE_CYC);
			fire(1'b1, no, ns);
			check("sync_ext", ns, c[1] ? 3 : 0);
			check("out_ext", no, 0);
		end
		$display("test routing done");
		reg_wr(sgp_pkg::ADDR_CTRL, 32'h0);
		for (int i = 0; i < 80; i++) begin
			p = (i < 32) ? 5'(i) : 5'($urandom_range(31, 0));
			@(posedge clk);
			cmd <= p;
			settle(6);
			m = next_mode(p, m);
			check("gate", bctl.gate, p[4] ? p[3:0] : 4'h0);
			check("mode", bctl.slow_charge, m);
			check("src", bctl.src, (!p[4] && p[1]) ? 8'he5 : 8'h00);
			reg_rd(sgp_pkg::ADDR_STATUS, d);
			check("status", d, exp_status(p, m, 2'h0, 1'b0));
		end
		$display("test servo done");
		for (int j = 0; j < 2; j++) begin
			for (int k = 0; k < 3; k++) begin
				vs[k] = (j == 0) ? 32'hffffff80 : $urandom;
				reg_wr(ra[k + 1][7:0], vs[k]);
			end
			for (int k = 0; k < 4; k++) begin
				logic s;
				s = k[1] & k[0];
				reg_wr(sgp_pkg::ADDR_CTRL, {29'h0, k[1], 2'h0});
				@(posedge clk);
				field <= k[0];
				settle(5);
				check("filt", fctl, {21'h0, s ? vs[2][6:0] : vs[1][6:0],
					s ? vs[0][6:4] : vs[0][2:0], k[0]});
			end
		end
		$display("test filter done");
		reg_wr(sgp_pkg::ADDR_CTRL, 32'h3);
		@(posedge clk);
		cmd   <= 5'h04;
		field <= 1'b0;
		settle(6);
		check("seek", bctl.slow_charge, 1'b0);
		@(posedge clk);
		rst <= 1'b1;
		cmd <= 5'h00;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		settle(6);
		check("pins_rerst", {pen, ien, tctl}, 32'h0);
		reg_rd(sgp_pkg::ADDR_STATUS, d);
		check("status_rerst", d, exp_status(5'h0, 1'b1, 2'h0, 1'b0));
		$display("test reset done");
		report_and_stop();
	end
endmodule : tb_top
